// [hdl/umsd_regs.sv]
// uart modem status, scratch, divisor and error-summary registers on ahb-lite
`timescale 1ns/10ps
`default_nettype none
module umsd_regs
  import umsd_pkg::*;
#(
  parameter int FIFO_DEPTH = 128
) (
  input  wire logic              core_clk_i,         // 250 MHz core clock
  input  wire logic              rstn_i,             // async reset, low
  // ahb-lite slave
  input  wire logic              hsel_i,             // slave select
  input  wire logic [31:0]       haddr_i,            // byte address
  input  wire logic [1:0]        htrans_i,           // transfer type
  input  wire logic              hwrite_i,           // write when high
  input  wire logic [2:0]        hsize_i,            // word only
  input  wire logic [31:0]       hwdata_i,           // write data
  input  wire logic              hready_i,           // bus ready
  output logic      [31:0]       hrdata_o,           // read data
  output logic                   hreadyout_o,        // slave ready
  output logic                   hresp_o,            // always okay
  // modem pins, active low
  input  wire logic              cts_n_i,            // clear to send
  input  wire logic              dsr_n_i,            // data set ready
  input  wire logic              ring_indicator_n_i, // ring indicator
  input  wire logic              carrier_detect_n_i, // carrier detect
  output logic                   rts_n_o,            // request to send
  output logic                   dtr_n_o,            // terminal ready
  // receive path side
  input  wire logic              rx_push_i,          // byte enters fifo
  input  wire logic              rx_push_err_i,      // it carries an error
  input  wire logic              rx_pop_i,           // byte leaves fifo
  input  wire logic              rx_pop_err_i,       // it carried an error
  input  wire logic [6:0]        rx_status_i,        // line status 6..0
  input  wire logic [7:0]        rx_data_i,          // receive holding byte
  output logic                   rx_rd_o,            // receive byte read
  // transmit, timing and interrupt side
  output logic      [7:0]        tx_data_o,          // transmit byte
  output logic                   tx_wr_o,            // transmit byte write
  output logic      [15:0]       baud_divisor_o,     // baud divisor
  output logic      [7:0]        line_format_o,      // line format byte
  output logic                   modem_irq_o,        // modem interrupt
  output logic                   irq_o               // event interrupt
);

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 1) begin : g_bad_depth
    $error("FIFO_DEPTH must be at least 1");
  end

  function automatic umsd_reg_e reg_decode(
    input logic [ADDR_W-1:0] a,
    input logic              div_en
  );
    umsd_reg_e r;
    r = REG_NONE;
    if (a == OFS_DATA_DIV_LO) begin
      r = div_en ? REG_DIV_LOW : REG_DATA;
    end else if (a == OFS_IE_DIV_HI) begin
      r = div_en ? REG_DIV_HIGH : REG_INT_EN;
    end else if (a == OFS_LINE_FORMAT) begin
      r = REG_LF;
    end else if (a == OFS_MODEM_CTRL) begin
      r = REG_MC;
    end else if (a == OFS_LINE_STATUS) begin
      r = REG_LS;
    end else if (a == OFS_MODEM_STATUS) begin
      r = REG_MS;
    end else if (a == OFS_SCRATCH) begin
      r = REG_SCR;
    end else if (a == OFS_EVT_STATUS) begin
      r = REG_EVT_ST;
    end else if (a == OFS_EVT_MASK) begin
      r = REG_EVT_MK;
    end
    return r;
  endfunction : reg_decode

  // ---------------- bus slave ----------------
  logic              dp_valid_reg;
  logic              dp_write_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  logic              rd_done_reg;
  logic [31:0]       rdata_reg;
  logic              addr_take;
  logic              wr_fire;
  logic              rd_fire;
  umsd_reg_e         cur_sel;

  logic [7:0]        tx_data_reg;
  logic              tx_wr_reg;
  logic              rx_rd_reg;
  logic [7:0]        interrupt_enable_reg;
  logic [7:0]        lf_reg;
  logic [MC_W-1:0]   mc_reg;
  logic [7:0]        scr_reg;
  logic [7:0]        div_low_reg;
  logic [7:0]        div_high_reg;
  logic [EVT_W-1:0]  evt_st_reg;
  logic [EVT_W-1:0]  evt_mk_reg;

  logic [ML_N-1:0]   pins_n_sync;
  logic [ML_N-1:0]   line_now;
  logic [ML_N-1:0]   line_prev_reg;
  logic [ML_N-1:0]   delta_reg;
  logic [ML_N-1:0]   delta_set;
  logic              loop_en;
  logic [CNT_W-1:0]  err_cnt_reg;
  logic [CNT_W-1:0]  err_cnt_next;
  logic              fifo_err;
  logic [EVT_W-1:0]  evt_set;
  logic [7:0]        ms_value;
  logic [7:0]        ls_value;
  logic [31:0]       rd_mux;

  assign addr_take = hsel_i & hready_i & htrans_i[HTRANS_ACT_BIT];
  // decode in the data phase so a format write just before is seen
  assign cur_sel   = reg_decode(dp_addr_reg, lf_reg[LF_DIV_EN_BIT]);
  assign wr_fire   = dp_valid_reg & dp_write_reg;
  // reads take one wait state so the read data leaves a flip-flop
  assign rd_fire   = dp_valid_reg & ~dp_write_reg & ~rd_done_reg;

  assign hreadyout_o = ~rd_fire;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_reg;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end else if (hreadyout_o) begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite_i;
      dp_addr_reg  <= haddr_i[ADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_done_reg <= 1'b0;
      rdata_reg   <= RST_RDATA;
    end else begin
      rd_done_reg <= rd_fire;
      if (rd_fire) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    case (cur_sel)
      REG_DATA:     rd_mux[7:0] = rx_data_i;
      REG_DIV_LOW:  rd_mux[7:0] = div_low_reg;
      REG_INT_EN:   rd_mux[7:0] = interrupt_enable_reg;
      REG_DIV_HIGH: rd_mux[7:0] = div_high_reg;
      REG_LF:       rd_mux[7:0] = lf_reg;
      REG_MC:       rd_mux[MC_W-1:0] = mc_reg;
      REG_LS:       rd_mux[7:0] = ls_value;
      REG_MS:       rd_mux[7:0] = ms_value;
      REG_SCR:      rd_mux[7:0] = scr_reg;
      REG_EVT_ST:   rd_mux[EVT_W-1:0] = evt_st_reg;
      REG_EVT_MK:   rd_mux[EVT_W-1:0] = evt_mk_reg;
      default:      rd_mux = '0;
    endcase
  end

  // ---------------- software registers ----------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      interrupt_enable_reg <= RST_BYTE;
      lf_reg               <= RST_BYTE;
      mc_reg               <= RST_MC;
      scr_reg              <= RST_BYTE;
    end else if (wr_fire) begin
      if (cur_sel == REG_INT_EN) begin
        interrupt_enable_reg <= hwdata_i[7:0];
      end else if (cur_sel == REG_LF) begin
        lf_reg <= hwdata_i[7:0];
      end else if (cur_sel == REG_MC) begin
        mc_reg <= hwdata_i[MC_W-1:0];
      end else if (cur_sel == REG_SCR) begin
        scr_reg <= hwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_low_reg  <= RST_BYTE;
      div_high_reg <= RST_BYTE;
    end else if (wr_fire) begin
      if (cur_sel == REG_DIV_LOW) begin
        div_low_reg <= hwdata_i[7:0];
      end else if (cur_sel == REG_DIV_HIGH) begin
        div_high_reg <= hwdata_i[7:0];
      end
    end
  end

  assign baud_divisor_o = {div_high_reg, div_low_reg};
  assign line_format_o  = lf_reg;

  // data register strobes toward the transmit and receive paths
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_data_reg <= RST_BYTE;
      tx_wr_reg   <= 1'b0;
      rx_rd_reg   <= 1'b0;
    end else begin
      tx_wr_reg <= wr_fire & (cur_sel == REG_DATA);
      rx_rd_reg <= rd_fire & (cur_sel == REG_DATA);
      if (wr_fire && cur_sel == REG_DATA) begin
        tx_data_reg <= hwdata_i[7:0];
      end
    end
  end

  assign tx_data_o = tx_data_reg;
  assign tx_wr_o   = tx_wr_reg;
  assign rx_rd_o   = rx_rd_reg;

  // ---------------- modem lines ----------------
  umsd_sync #(
    .WIDTH   (ML_N),
    .RST_VAL (RST_PINS_N)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    ({carrier_detect_n_i, ring_indicator_n_i,
                  dsr_n_i, cts_n_i}),
    .sync_o     (pins_n_sync)
  );

  assign loop_en = mc_reg[MC_LOOP_BIT];

  always_comb begin
    if (loop_en) begin
      line_now[ML_CTS] = mc_reg[MC_RTS_BIT];
      line_now[ML_DSR] = mc_reg[MC_DTR_BIT];
      line_now[ML_RING] = mc_reg[MC_OUT1_BIT];
      line_now[ML_CARRIER] = mc_reg[MC_OUT2_BIT];
    end else begin
      line_now = ~pins_n_sync;
    end
  end

  // in loopback the control pins rest inactive
  assign rts_n_o = loop_en | ~mc_reg[MC_RTS_BIT];
  assign dtr_n_o = loop_en | ~mc_reg[MC_DTR_BIT];

  always_comb begin
    delta_set = line_now ^ line_prev_reg;
    // ring pin going high means the state bit falls
    delta_set[ML_RING] = line_prev_reg[ML_RING]
                         & ~line_now[ML_RING];
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_prev_reg <= RST_DELTA;
    end else begin
      line_prev_reg <= line_now;
    end
  end

  // a change in the read cycle survives the clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delta_reg <= RST_DELTA;
    end else if (rd_fire && cur_sel == REG_MS) begin
      delta_reg <= delta_set;
    end else begin
      delta_reg <= delta_reg | delta_set;
    end
  end

  assign ms_value    = {line_now, delta_reg};
  assign modem_irq_o = (|delta_reg)
                       & interrupt_enable_reg[IE_MODEM_BIT];

  // ---------------- receive error summary ----------------
  always_comb begin
    err_cnt_next = err_cnt_reg;
    if (rx_push_i && rx_push_err_i) begin
      err_cnt_next = err_cnt_next + 1'b1;
    end
    if (rx_pop_i && rx_pop_err_i && err_cnt_next != '0) begin
      err_cnt_next = err_cnt_next - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_cnt_reg <= '0;
    end else begin
      err_cnt_reg <= err_cnt_next;
    end
  end

  assign fifo_err = (err_cnt_reg != '0);
  assign ls_value = {fifo_err, rx_status_i};

  // ---------------- event interrupt ----------------
  assign evt_set[EVT_MODEM_BIT] = |delta_set;
  assign evt_set[EVT_RXERR_BIT] = ~fifo_err & (err_cnt_next != '0);

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_st_reg <= RST_EVT;
    end else if (wr_fire && cur_sel == REG_EVT_ST) begin
      evt_st_reg <= (evt_st_reg & ~hwdata_i[EVT_W-1:0]) | evt_set;
    end else begin
      evt_st_reg <= evt_st_reg | evt_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_mk_reg <= RST_EVT;
    end else if (wr_fire && cur_sel == REG_EVT_MK) begin
      evt_mk_reg <= hwdata_i[EVT_W-1:0];
    end
  end

  assign irq_o = |(evt_st_reg & evt_mk_reg);

endmodule : umsd_regs
`default_nettype wire

// [pkg/umsd_pkg.sv]
// constants and types for the uart modem status, scratch and divisor registers
package umsd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] OFS_DATA_DIV_LO  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IE_DIV_HI    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LINE_FORMAT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATUS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SCRATCH      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK     = 8'h24;

  // field positions
  localparam int LF_DIV_EN_BIT   = 7;
  localparam int MC_DTR_BIT      = 0;
  localparam int MC_RTS_BIT      = 1;
  localparam int MC_OUT1_BIT     = 2;
  localparam int MC_OUT2_BIT     = 3;
  localparam int MC_LOOP_BIT     = 4;
  localparam int MC_W            = 5;
  localparam int IE_MODEM_BIT    = 3;
  localparam int LS_FIFO_ERR_BIT = 7;
  // modem line index, same for change flag and state nibble
  localparam int ML_CTS     = 0;
  localparam int ML_DSR     = 1;
  localparam int ML_RING    = 2;
  localparam int ML_CARRIER = 3;
  localparam int ML_N       = 4;
  localparam int EVT_MODEM_BIT = 0;
  localparam int EVT_RXERR_BIT = 1;
  localparam int EVT_W         = 2;

  // reset values
  localparam logic [7:0]       RST_BYTE     = 8'h00;
  localparam logic [MC_W-1:0]  RST_MC       = 5'h00;
  localparam logic [ML_N-1:0]  RST_DELTA    = 4'h0;
  localparam logic [ML_N-1:0]  RST_PINS_N   = 4'hF;
  localparam logic [EVT_W-1:0] RST_EVT      = 2'h0;
  localparam logic [DATA_W-1:0] RST_RDATA   = 32'h0000_0000;

  // ahb-lite transfer type msb marks nonseq and seq
  localparam int HTRANS_ACT_BIT = 1;

  typedef enum logic [3:0] {
    REG_NONE, REG_DATA, REG_DIV_LOW, REG_INT_EN, REG_DIV_HIGH,
    REG_LF, REG_MC, REG_LS, REG_MS, REG_SCR, REG_EVT_ST, REG_EVT_MK
  } umsd_reg_e;

endpackage : umsd_pkg

// [hdl/umsd_sync.sv]
// two flip-flop synchroniser for the modem input pins
`timescale 1ns/10ps
`default_nettype none
module umsd_sync #(
  parameter int                WIDTH    = 4,
  parameter logic [WIDTH-1:0]  RST_VAL  = '1
) (
  input  wire logic             core_clk_i, // core clock
  input  wire logic             rstn_i,     // async reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // pins from outside
  output logic      [WIDTH-1:0] sync_o      // synchronised copy
);
  logic [WIDTH-1:0] meta_reg;

  // meta_reg feeds only the second stage
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : umsd_sync
`default_nettype wire

// [testbench/umsd_regs_checker.sv]
// concurrent checks on the modem status and divisor register block
`timescale 1ns/10ps
`default_nettype none
module umsd_regs_checker (
  input wire logic        core_clk_i,     // clock
  input wire logic        rstn_i,         // reset, low
  input wire logic        hsel_i,         // select
  input wire logic [1:0]  htrans_i,       // type
  input wire logic        hwrite_i,       // write
  input wire logic        hready_i,       // bus ready
  input wire logic        hreadyout_o,    // slave ready
  input wire logic        hresp_o,        // response
  input wire logic        rx_rd_o,        // rx read pulse
  input wire logic        tx_wr_o,        // tx write pulse
  input wire logic [15:0] baud_divisor_o, // divisor
  input wire logic [7:0]  line_format_o,  // format
  input wire logic        modem_irq_o     // modem irq
);
  logic wr_dp;
  logic rd_dp;
  wire logic take = hsel_i & hready_i & htrans_i[1];

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // side effects must trace back to a finished data phase
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_dp <= 1'b0;
      rd_dp <= 1'b0;
    end else begin
      wr_dp <= take & hwrite_i;
      rd_dp <= take & ~hwrite_i;
    end
  end

  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("slave response not okay");
  a_read_wait: assert property (take && !hwrite_i |=>
    !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  a_div_change: assert property ($changed(baud_divisor_o) |->
    $past(wr_dp && line_format_o[7])) else $error("divisor moved");
  a_format_change: assert property ($changed(line_format_o) |->
    $past(wr_dp)) else $error("line format moved");
  a_irq_fall: assert property ($fell(modem_irq_o) |->
    $past(rd_dp || wr_dp)) else $error("modem irq dropped");
  a_rd_pulse: assert property (rx_rd_o |-> $past(rd_dp) ##1 !rx_rd_o)
    else $error("rx read pulse wrong");
  a_tx_pulse: assert property (tx_wr_o |->
    $past(wr_dp) && !line_format_o[7] ##1 !tx_wr_o)
    else $error("tx write pulse wrong");

  c_read: cover property (take && !hwrite_i);
  c_irq_fall: cover property ($fell(modem_irq_o));
  c_div: cover property ($changed(baud_divisor_o));
endmodule : umsd_regs_checker

bind umsd_regs umsd_regs_checker i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_rd_o(rx_rd_o),
  .tx_wr_o(tx_wr_o), .baud_divisor_o(baud_divisor_o),
  .line_format_o(line_format_o), .modem_irq_o(modem_irq_o)
);
`default_nettype wire

// [testbench/umsd_modem_model.sv]
// far-side modem model driving the active-low status pins
`timescale 1ns/10ps
`default_nettype none
module umsd_modem_model (
  input  wire logic       core_clk_i, // clock
  input  wire logic [3:0] want_n_i,   // requested levels
  input  wire logic [3:0] dly_i,      // slowness in cycles
  output logic      [3:0] pins_n_o    // cts, dsr, ring, carrier
);
  logic [3:0] cnt = 4'h0;
  // pins idle at the inactive high level
  initial pins_n_o = 4'hF;
  always @(posedge core_clk_i) begin
    if (want_n_i === pins_n_o) begin
      cnt <= 4'h0;
    end else if (cnt >= dly_i) begin
      pins_n_o <= want_n_i;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : umsd_modem_model
`default_nettype wire

// [testbench/umsd_regs_tb_top.sv]
// self-checking bench for the modem status, scratch and divisor registers
`timescale 1ns/10ps
`default_nettype none
module umsd_regs_tb_top
  import umsd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0, hready, hresp, rts_n, dtr_n, mirq, irq;
  logic        push = 1'b0, push_err = 1'b0, pop = 1'b0, pop_err = 1'b0;
  logic [6:0]  rx_status = 7'h0;
  logic [7:0]  rx_data = 8'h0, tx_data, lf;
  logic        rx_rd, tx_wr;
  logic [15:0] baud;
  logic [3:0]  want_n = 4'hF, dly = 4'h0, pins_n, fl;
  integer      seed = 65;
  int          error_cnt = 0, total_checks = 0, cycles = 0;

  always #2 clk = ~clk;

  umsd_modem_model i_modem (.core_clk_i(clk), .want_n_i(want_n),
    .dly_i(dly), .pins_n_o(pins_n));

  umsd_regs i_dut (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .cts_n_i(pins_n[0]), .dsr_n_i(pins_n[1]),
    .ring_indicator_n_i(pins_n[2]), .carrier_detect_n_i(pins_n[3]),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .rx_push_i(push),
    .rx_push_err_i(push_err), .rx_pop_i(pop), .rx_pop_err_i(pop_err),
    .rx_status_i(rx_status), .rx_data_i(rx_data), .rx_rd_o(rx_rd),
    .tx_data_o(tx_data), .tx_wr_o(tx_wr), .baud_divisor_o(baud),
    .line_format_o(lf), .modem_irq_o(mirq), .irq_o(irq));

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      error_cnt++;
    end
  endtask : chk

  // samples mid-cycle so the edge that finishes a phase is not raced
  task automatic cyc(output logic [31:0] q);
    do @(negedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : cyc

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    cyc(q);
    @(posedge clk);
    htrans <= 2'h0;
    cyc(q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    cyc(q);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    cyc(q);
    @(negedge clk);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask : rchk

  task automatic fifo(input logic po, input logic er);
    @(posedge clk);
    push <= ~po;
    pop <= po;
    push_err <= er;
    pop_err <= er;
    @(posedge clk);
    push <= 1'b0;
    pop <= 1'b0;
    @(negedge clk);
  endtask : fifo

  function automatic logic [3:0] f_loop(input logic [3:0] mc);
    return {mc[3], mc[2], mc[0], mc[1]};
  endfunction : f_loop

  initial begin : main
    logic [31:0] q;
    logic [7:0]  v;
    logic [15:0] dv;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rx_status <= 7'($random(seed));
    rx_data <= 8'($random(seed));
    rchk(OFS_SCRATCH, 32'h0);
    rchk(OFS_MODEM_STATUS, 32'h0);
    rchk(OFS_LINE_STATUS, {25'h0, rx_status});
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(OFS_SCRATCH, {24'h0, v});
      rchk(OFS_SCRATCH, {24'h0, v});
    end
    rchk(8'h28, 32'h0);
    rchk(8'h1E, 32'h0);
    dv = 16'($random(seed));
    wr(OFS_LINE_FORMAT, 32'h80);
    wr(OFS_DATA_DIV_LO, {24'h0, dv[7:0]});
    wr(OFS_IE_DIV_HI, {24'h0, dv[15:8]});
    chk({16'h0, baud}, {16'h0, dv});
    rchk(OFS_IE_DIV_HI, {24'h0, dv[15:8]});
    wr(OFS_LINE_FORMAT, 32'h03);
    wr(OFS_DATA_DIV_LO, 32'h5A);
    // the write pulse stands in the cycle after the data phase
    chk({31'h0, tx_wr}, 32'h1);
    chk({8'h0, lf, tx_data, 8'h0}, {16'h03, 8'h5A, 8'h0});
    chk({16'h0, baud}, {16'h0, dv});
    rchk(OFS_DATA_DIV_LO, {24'h0, rx_data});
    chk({31'h0, rx_rd}, 32'h1);
    wr(OFS_IE_DIV_HI, 32'h08);
    for (int i = 0; i < 4; i++) begin
      for (int lv = 0; lv < 2; lv++) begin
        dly <= 4'($random(seed)) & 4'h3;
        want_n[i] <= lv[0];
        repeat (12) @(negedge clk);
        // a ring pin falling marks no change, only its rise does
        fl = (i == 2 && lv == 0) ? 4'h0 : 4'h1 << i;
        chk({31'h0, mirq}, {31'h0, |fl});
        rd(OFS_MODEM_STATUS, q);
        chk({q[31:8], 4'h0, q[3:0]}, {28'h0, fl});
        chk({28'h0, q[7:4]}, {28'h0, ~want_n});
        chk({31'h0, mirq}, 32'h0);
      end
    end
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(OFS_MODEM_CTRL, {24'h0, 4'h1, v[3:0]});
      rd(OFS_MODEM_STATUS, q);
      chk({28'h0, q[7:4]}, {28'h0, f_loop(v[3:0])});
      chk({30'h0, rts_n, dtr_n}, 32'h3);
    end
    wr(OFS_MODEM_CTRL, 32'h03);
    rd(OFS_MODEM_STATUS, q);
    chk({30'h0, rts_n, dtr_n}, 32'h0);
    wr(OFS_EVT_STATUS, 32'h3);
    wr(OFS_EVT_MASK, 32'h0);
    fifo(1'b0, 1'b1);
    fifo(1'b0, 1'b1);
    fifo(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_EVT_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EVT_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rchk(OFS_LINE_STATUS, {24'h0, 1'b1, rx_status});
    fifo(1'b1, 1'b1);
    rchk(OFS_LINE_STATUS, {24'h0, 1'b1, rx_status});
    fifo(1'b1, 1'b1);
    rchk(OFS_LINE_STATUS, {24'h0, 1'b0, rx_status});
    end_sim();
  end
endmodule : umsd_regs_tb_top
`default_nettype wire
